//--- tmc_consts.vh
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH

// ----------------------------------------------------------------------
// Register map (byte addresses on the APB bus)
// ----------------------------------------------------------------------
`define TMC_OFF_MODE 12'h000
`define TMC_OFF_LOAD 12'h004
`define TMC_OFF_HOLD 12'h008
`define TMC_OFF_CMD 12'h00C
`define TMC_OFF_STAT 12'h010
`define TMC_OFF_CNT 12'h014

// ----------------------------------------------------------------------
// Reset values and mode fields
// ----------------------------------------------------------------------
`define TMC_MODE_RST 16'h0B00
`define TMC_MB_UP 4
`define TMC_MB_BCD 3
`define TMC_MB_REP 5
`define TMC_MB_RLD 6
`define TMC_MB_SPG 7
`define TMC_MB_POL 12
`define TMC_OFORM_HIZ 3'h4
`define TMC_OFORM_HI 3'h1
`define TMC_OFORM_TOG 3'h2
`define TMC_OFORM_LO 3'h5
`define TMC_OFORM_GND 3'h0
`define TMC_GATE_NONE 3'h0

// ----------------------------------------------------------------------
// Command codes written to the command register
// ----------------------------------------------------------------------
`define TMC_CMD_ARM 4'h1
`define TMC_CMD_LOAD 4'h2
`define TMC_CMD_LDARM 4'h3
`define TMC_CMD_DISARM 4'h4
`define TMC_CMD_SETOUT 4'h5
`define TMC_CMD_CLROUT 4'h6
`define TMC_CMD_MRESET 4'hF

// ----------------------------------------------------------------------
// Terminal-count thresholds
// ----------------------------------------------------------------------
`define TMC_TC_DOWN 16'h0001
`define TMC_TC_BCD 16'h9999
`define TMC_TC_BIN 16'hFFFF

`endif

//--- tmc_edge.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Edge detector for an input taken as synchronous to pclk
// ----------------------------------------------------------------------
module tmc_edge (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Sampled signal
  input wire sig_in,
  input wire fall_sel,
  // Results
  output reg level_q,
  output wire edge_p
);

  reg prev_q;

  // Registers the level and the previous level.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      level_q <= sig_in;
      prev_q <= level_q;
    end
  end

  // Active edge is rising unless falling is selected.
  assign edge_p = fall_sel ? (prev_q & ~level_q) : (~prev_q & level_q);

endmodule // tmc_edge

`default_nettype wire

//--- tmc_counter.v
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "tmc_consts.vh"

// Summary of operation
// - Keying mode: gate low reloads from load register, gate high from hold.
// - Keying mode: gate never starts or pauses; repeats until disarm.
// - Save mode: gate edge starts counting only while armed.
// - Save mode: after trigger count every source edge until terminal count.
// - Save mode: gate edges during counting copy count into hold register.
// - Save mode: terminal count reloads from load and stops; retrigger restarts.
// - Counter owns a 16-bit mode register with all option fields.
// - Reset and master reset command set the mode register to 0B00.
// - Three low mode bits select output form.
// - Terminal count follows 0001 down, 9999 BCD up, FFFF binary up.
// - Terminal count lasts one source period, armed or not, unless a load command ends it.
// - Every terminal count parallel-loads the counter from the selected register.
// - Toggled output flips on the trailing edge of each terminal count.
// - Minimum-delay one-shot toggles on second source pulse after trigger.
// - Toggled output only inverts; set and clear commands give start level.
// - No gating with special gating bit set: gate picks reload register.

module tmc_counter (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Counting source and gate
  input wire count_src,
  input wire gate_in,
  // Output pin
  output reg out_o,
  output reg out_oe,
  output reg terminal_count_pulse
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg [15:0] counter_mode_reg;
  reg [15:0] load_q;
  reg [15:0] hold_q;
  reg [15:0] cnt_q;
  reg armed_q;
  reg run_q;
  reg tc_q;
  reg tog_q;
  reg [1:0] tc_seen_q;
  wire src_lvl;
  wire src_edge;
  wire gate_lvl;
  wire gate_edge;

  // Mode register fields.
  wire [2:0] oform = counter_mode_reg[2:0];
  wire up_m = counter_mode_reg[`TMC_MB_UP];
  wire bcd_m = counter_mode_reg[`TMC_MB_BCD];
  wire rep_m = counter_mode_reg[`TMC_MB_REP];
  wire rld_m = counter_mode_reg[`TMC_MB_RLD];
  wire special_gating_bit = counter_mode_reg[`TMC_MB_SPG];
  wire [2:0] gate_ctl = counter_mode_reg[15:13];
  wire no_gate = (gate_ctl == `TMC_GATE_NONE);
  // Keying mode: no gating, special bit, hold reload enabled, repeating.
  wire fsk_m = no_gate & special_gating_bit & rld_m & rep_m;
  // Save mode: edge gating with special gating and repeat bits clear and hold reload set.
  wire save_m = ~no_gate & gate_ctl[2] & ~special_gating_bit & rld_m & ~rep_m;

  // --------------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------------
  // Source polarity follows the mode register; the gate is active high.
  tmc_edge u_src (
    .pclk(pclk),
    .presetn(presetn),
    .sig_in(count_src),
    .fall_sel(counter_mode_reg[`TMC_MB_POL]),
    .level_q(src_lvl),
    .edge_p(src_edge)
  );

  tmc_edge u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .sig_in(gate_in),
    .fall_sel(1'b0),
    .level_q(gate_lvl),
    .edge_p(gate_edge)
  );

  // --------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------
  // Tells whether the present count is the last before terminal count.
  function tc_next;
    input [15:0] v;
    input up;
    input bcd;
    begin
      if (!up) tc_next = (v == `TMC_TC_DOWN);
      else if (bcd) tc_next = (v == `TMC_TC_BCD);
      else tc_next = (v == `TMC_TC_BIN);
    end
  endfunction

  // Steps one BCD digit in the requested direction.
  function [3:0] bcd_digit;
    input [3:0] d;
    input up;
    begin
      if (up) bcd_digit = (d == 4'h9) ? 4'h0 : d + 4'h1;
      else bcd_digit = (d == 4'h0) ? 4'h9 : d - 4'h1;
    end
  endfunction

  // Next count value in binary or BCD.
  reg [15:0] step_v;
  reg carry;
  integer i;
  always @* begin
    step_v = cnt_q;
    carry = 1'b1;
    if (!bcd_m) begin
      step_v = up_m ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (carry) begin
          step_v[i*4 +: 4] = bcd_digit(cnt_q[i*4 +: 4], up_m);
          carry = up_m ? (cnt_q[i*4 +: 4] == 4'h9) : (cnt_q[i*4 +: 4] == 4'h0);
        end
      end
    end
  end

  // Reload register choice.
  wire gate_sel = fsk_m | (no_gate & special_gating_bit);
  wire [15:0] reload_v = (gate_sel & gate_lvl) ? hold_q : load_q;

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  wire acc = psel & penable & ~pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit = (paddr == `TMC_OFF_MODE) | (paddr == `TMC_OFF_LOAD) |
             (paddr == `TMC_OFF_HOLD) | (paddr == `TMC_OFF_CMD) |
             (paddr == `TMC_OFF_STAT) | (paddr == `TMC_OFF_CNT);
  wire cmd_v = wr & (paddr == `TMC_OFF_CMD);
  wire [3:0] cmd = pwdata[3:0];
  wire c_load = cmd_v & ((cmd == `TMC_CMD_LOAD) | (cmd == `TMC_CMD_LDARM));
  wire c_arm = cmd_v & ((cmd == `TMC_CMD_ARM) | (cmd == `TMC_CMD_LDARM));
  wire c_disarm = cmd_v & (cmd == `TMC_CMD_DISARM);
  wire c_mrst = cmd_v & (cmd == `TMC_CMD_MRESET);

  // Counting is allowed when armed; save mode further needs a trigger.
  wire may_count = armed_q & (~save_m | run_q);
  // A source edge always counts while terminal count is active.
  wire do_count = src_edge & (may_count | tc_q);
  wire hit_tc = do_count & tc_next(cnt_q, up_m, bcd_m);

  // APB responder: one wait state, error on unmapped address.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~hit;
      if (rd) begin
        case (paddr)
          `TMC_OFF_MODE: prdata <= {16'h0000, counter_mode_reg};
          `TMC_OFF_LOAD: prdata <= {16'h0000, load_q};
          `TMC_OFF_HOLD: prdata <= {16'h0000, hold_q};
          `TMC_OFF_STAT: prdata <= {27'h000_0000, gate_lvl, tog_q, tc_q, run_q, armed_q};
          `TMC_OFF_CNT: prdata <= {16'h0000, cnt_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Mode, load and hold registers
  // --------------------------------------------------------------------
  // Mode register reset and master reset give the default configuration.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_mode_reg <= `TMC_MODE_RST;
      load_q <= 16'h0000;
    end else if (c_mrst) begin
      counter_mode_reg <= `TMC_MODE_RST;
      load_q <= 16'h0000;
    end else if (wr & (paddr == `TMC_OFF_MODE)) begin
      counter_mode_reg <= pwdata[15:0];
    end else if (wr & (paddr == `TMC_OFF_LOAD)) begin
      load_q <= pwdata[15:0];
    end
  end

  // Hold register: save-mode gate edges sample the running count.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 16'h0000;
    end else if (c_mrst) begin
      hold_q <= 16'h0000;
    end else if (save_m & run_q & gate_edge) begin
      hold_q <= cnt_q;
    end else if (wr & (paddr == `TMC_OFF_HOLD)) begin
      hold_q <= pwdata[15:0];
    end
  end

  // --------------------------------------------------------------------
  // Counter, arming and terminal count
  // --------------------------------------------------------------------
  // Reload on terminal count and on load commands; else count qualified edges.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      armed_q <= 1'b0;
      run_q <= 1'b0;
      tc_q <= 1'b0;
      tc_seen_q <= 2'b00;
    end else if (c_mrst) begin
      cnt_q <= 16'h0000;
      armed_q <= 1'b0;
      run_q <= 1'b0;
      tc_q <= 1'b0;
      tc_seen_q <= 2'b00;
    end else begin
      if (c_load) begin
        cnt_q <= reload_v;
        tc_q <= 1'b0;
      end else if (hit_tc) begin
        cnt_q <= reload_v;
        tc_q <= 1'b1;
      end else if (do_count) begin
        cnt_q <= step_v;
        tc_q <= 1'b0;
      end
      // Save mode trigger needs an armed counter.
      if (save_m & armed_q & ~run_q & gate_edge) begin
        run_q <= 1'b1;
      end else if (save_m & hit_tc) begin
        run_q <= 1'b0;
      end
      // Arming: keying mode runs until disarm; one-shot modes stop at TC.
      if (c_disarm) begin
        armed_q <= 1'b0;
      end else if (c_arm) begin
        armed_q <= 1'b1;
        tc_seen_q <= 2'b00;
      end else if (hit_tc & ~rep_m & ~save_m) begin
        armed_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Output stage
  // --------------------------------------------------------------------
  // Toggle on the trailing edge of terminal count; commands set the start.
  wire tc_trail = tc_q & do_count & ~hit_tc;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_q <= 1'b0;
    end else if (c_mrst | (cmd_v & (cmd == `TMC_CMD_CLROUT))) begin
      tog_q <= 1'b0;
    end else if (cmd_v & (cmd == `TMC_CMD_SETOUT)) begin
      tog_q <= 1'b1;
    end else if ((tc_trail | (tc_q & hit_tc)) | (tc_q & c_load)) begin
      tog_q <= ~tog_q;
    end
  end

  // Output form select, registered straight to the pins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_o <= 1'b0;
      out_oe <= 1'b1;
      terminal_count_pulse <= 1'b0;
    end else begin
      terminal_count_pulse <= tc_q;
      case (oform)
        `TMC_OFORM_HIZ: begin
          out_o <= 1'b0;
          out_oe <= 1'b0;
        end
        `TMC_OFORM_HI: begin
          out_o <= tc_q;
          out_oe <= 1'b1;
        end
        `TMC_OFORM_TOG: begin
          out_o <= tog_q;
          out_oe <= 1'b1;
        end
        `TMC_OFORM_LO: begin
          out_o <= ~tc_q;
          out_oe <= 1'b1;
        end
        default: begin
          out_o <= 1'b0;
          out_oe <= 1'b1;
        end
      endcase
    end
  end

  // Source level is observed only through its edge detector.
  wire unused_ok = src_lvl & tc_seen_q[0] & tc_seen_q[1];

endmodule // tmc_counter

`default_nettype wire

//--- tmc_counter_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "tmc_consts.vh"

// ----
// Port checker for the counter block
// ----
module tmc_counter_assertions (
  // APB side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin side
  input wire logic count_src,
  input wire logic gate_in,
  input wire logic out_o,
  input wire logic out_oe,
  input wire logic terminal_count_pulse
);
  logic [15:0] mode_q;
  logic done;
  logic [2:0] form;

  // Completed writes and the output form field.
  assign done = psel && penable && pready && pwrite;
  assign form = mode_q[2:0];

  // Shadow of the mode register so the checks know the output form.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `TMC_MODE_RST;
    end else if (done && paddr == `TMC_OFF_MODE) begin
      mode_q <= pwdata[15:0];
    end else if (done && paddr == `TMC_OFF_CMD && pwdata[3:0] == `TMC_CMD_MRESET) begin
      mode_q <= `TMC_MODE_RST;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after the access edge");
  a_ready_cause: assert property (!(psel && penable) |=> !pready)
    else $error("pready without an access");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'h0))
    else $error("pslverr does not match the address map");
  a_data_upper: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_tc_width: assert property ($rose(terminal_count_pulse) |=> terminal_count_pulse)
    else $error("terminal count shorter than a source period");
  a_toggle_trail: assert property (form == `TMC_OFORM_TOG && $fell(terminal_count_pulse)
    |-> ##[0:2] $changed(out_o))
    else $error("toggled output did not flip at terminal count end");
  a_form_off: assert property (form == `TMC_OFORM_HIZ && $past(form) == `TMC_OFORM_HIZ
    |-> !out_oe)
    else $error("pin driven in off form");
  a_form_gnd: assert property (form == `TMC_OFORM_GND && $past(form) == `TMC_OFORM_GND
    |-> out_oe && !out_o)
    else $error("ground form not driving low");
endmodule // tmc_counter_assertions

`default_nettype wire

//--- tmc_src_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----
// Source and gate driver on the pin side
// ----
module tmc_src_model (
  // Clock
  input wire logic pclk,
  // Pins
  output logic count_src,
  output logic gate_in
);
  // Both pins idle low; the source stands still between bursts.
  initial begin
    count_src = 1'b0;
    gate_in = 1'b0;
  end

  // Sends n source periods of eight clocks each.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk);
      count_src <= 1'b1;
      repeat (4) @(posedge pclk);
      count_src <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  // Moves the gate level and lets the block see it.
  task automatic set_gate(input logic v);
    @(posedge pclk);
    gate_in <= v;
    repeat (4) @(posedge pclk);
  endtask
endmodule // tmc_src_model

`default_nettype wire

//--- counter_mode_output_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "tmc_consts.vh"

// ----
// Self-checking bench
// ----
module counter_mode_output_control_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic count_src, gate_in, out_o, out_oe, tcp, e, tc_d;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int miscompares, checks, tcn, cyc;
  logic [15:0] tmode [3] = '{16'h00E2, 16'h00F2, 16'h00FA};
  logic [15:0] tload [3] = '{16'h0002, 16'hFFFE, 16'h9998};

  tmc_counter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_src(count_src), .gate_in(gate_in), .out_o(out_o),
    .out_oe(out_oe), .terminal_count_pulse(tcp));
  tmc_src_model PM (.pclk(pclk), .count_src(count_src), .gate_in(gate_in));

  // Clock of 8 ns period.
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  // Counts terminal count rises and cuts a hang short.
  always @(posedge pclk) begin
    tc_d <= tcp;
    if (tcp === 1'b1 && tc_d === 1'b0) tcn++;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 16'h0000);
  endtask

  task automatic cmd(input logic [3:0] c);
    apb(1'b1, `TMC_OFF_CMD, {12'h000, c});
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence.
  initial begin
    {psel, penable, pwrite, presetn, tc_d} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`TMC_OFF_MODE);
    chk(r[15:0], `TMC_MODE_RST);
    chk({14'h0000, out_oe, out_o}, 16'h0002);
    rd(12'h01C);
    chk({15'h0000, e}, 16'h0001);
    wr(`TMC_OFF_MODE, 16'h0004);
    rd(`TMC_OFF_MODE);
    chk(r[15:0], 16'h0004);
    chk({15'h0000, out_oe}, 16'h0000);
    cmd(`TMC_CMD_MRESET);
    rd(`TMC_OFF_MODE);
    chk(r[15:0], `TMC_MODE_RST);
    $display("test registers done");
    wr(`TMC_OFF_MODE, 16'h00E2);
    wr(`TMC_OFF_LOAD, 16'h0003);
    wr(`TMC_OFF_HOLD, 16'h0005);
    cmd(`TMC_CMD_LOAD);
    rd(`TMC_OFF_CNT);
    chk(r[15:0], 16'h0003);
    PM.set_gate(1'b1);
    cmd(`TMC_CMD_LOAD);
    rd(`TMC_OFF_CNT);
    chk(r[15:0], 16'h0005);
    PM.set_gate(1'b0);
    cmd(`TMC_CMD_LOAD);
    cmd(`TMC_CMD_SETOUT);
    chk({15'h0000, out_o}, 16'h0001);
    tcn = 0;
    cmd(`TMC_CMD_ARM);
    PM.pulse(10);
    chk(tcn[15:0], 16'h0003);
    chk({15'h0000, out_o}, 16'h0000);
    cmd(`TMC_CMD_DISARM);
    for (int i = 0; i < 3; i++) begin
      wr(`TMC_OFF_MODE, tmode[i]);
      wr(`TMC_OFF_LOAD, tload[i]);
      cmd(`TMC_CMD_LOAD);
      tcn = 0;
      cmd(`TMC_CMD_ARM);
      PM.pulse(2);
      chk(tcn[15:0], 16'h0001);
      cmd(`TMC_CMD_DISARM);
    end
    $display("test keying done");
    wr(`TMC_OFF_MODE, 16'h8042);
    wr(`TMC_OFF_LOAD, 16'h000A);
    cmd(`TMC_CMD_LOAD);
    cmd(`TMC_CMD_LOAD);
    PM.set_gate(1'b1);
    PM.pulse(3);
    rd(`TMC_OFF_CNT);
    chk(r[15:0], 16'h000A);
    PM.set_gate(1'b0);
    cmd(`TMC_CMD_LDARM);
    PM.set_gate(1'b1);
    PM.pulse(4);
    rd(`TMC_OFF_CNT);
    chk(r[15:0], 16'h0006);
    PM.set_gate(1'b0);
    PM.set_gate(1'b1);
    rd(`TMC_OFF_HOLD);
    chk(r[15:0], 16'h0006);
    PM.pulse(2);
    rd(`TMC_OFF_CNT);
    chk(r[15:0], 16'h0004);
    tcn = 0;
    PM.pulse(5);
    chk(tcn[15:0], 16'h0001);
    rd(`TMC_OFF_CNT);
    chk(r[15:0], 16'h0009);
    PM.pulse(2);
    rd(`TMC_OFF_CNT);
    chk(r[15:0], 16'h0009);
    $display("test save done");
    end_of_test();
  end
endmodule // counter_mode_output_control_tb_top

bind tmc_counter tmc_counter_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .count_src(count_src), .gate_in(gate_in),
  .out_o(out_o), .out_oe(out_oe), .terminal_count_pulse(terminal_count_pulse));

`default_nettype wire
